// >>> verilog/scui_pkg.sv
// Package: register map, field layout and types of the card event unit
package scui_pkg;

  // Special function register addresses
  localparam logic [7:0] SCUI_ADDR_SELECTION = 8'h00_AB;
  localparam logic [7:0] SCUI_ADDR_EVENT     = 8'h00_AE;

  // Event bit positions, shared by identification and enable registers
  localparam int SCUI_BIT_TX_EMPTY  = 7;
  localparam int SCUI_BIT_RESERVED  = 6;
  localparam int SCUI_BIT_OVERCURR  = 5;
  localparam int SCUI_BIT_VOLTAGE   = 4;
  localparam int SCUI_BIT_WAIT      = 3;
  localparam int SCUI_BIT_TX_DONE   = 2;
  localparam int SCUI_BIT_RX_DONE   = 1;
  localparam int SCUI_BIT_PARITY    = 0;

  // Selection register fields
  localparam int SCUI_SEL_GUARD     = 6;
  localparam int SCUI_SEL_REPEAT    = 4;
  localparam int SCUI_SEL_PRESC_HI  = 3;
  localparam int SCUI_SEL_PRESC_LO  = 2;
  localparam int SCUI_SEL_ALTCLK    = 1;
  localparam int SCUI_SEL_BANK      = 0;

  // Reset values; reserved bits read zero
  localparam logic [7:0] SCUI_RST_EVENT     = 8'h00_00;
  localparam logic [7:0] SCUI_RST_ENABLE    = 8'h00_00;
  localparam logic [7:0] SCUI_RST_SELECTION = 8'h00_08;
  // Writable bits of each register
  localparam logic [7:0] SCUI_MASK_ENABLE   = 8'h00_BF;
  localparam logic [7:0] SCUI_MASK_SELECTION = 8'h00_5F;
  localparam logic [7:0] SCUI_ZERO          = 8'h00_00;

  // Hardware event strobes from the card interface engine
  typedef struct packed {
    logic txEmpty;
    logic overCurrent;
    logic voltageOut;
    logic waitExpired;
    logic txDone;
    logic rxDone;
    logic parityBad;
  } scui_events_t;

  // Special function register access from the core
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scui_sfr_req_t;

  // Event codes of the priority resolver, one-hot
  typedef enum logic [7:0] {
    SCUI_SRC_NONE     = 8'h00_00,
    SCUI_SRC_PARITY   = 8'h00_01,
    SCUI_SRC_RX_DONE  = 8'h00_02,
    SCUI_SRC_TX_DONE  = 8'h00_04,
    SCUI_SRC_WAIT     = 8'h00_08,
    SCUI_SRC_VOLTAGE  = 8'h00_10,
    SCUI_SRC_OVERCURR = 8'h00_20,
    SCUI_SRC_TX_EMPTY = 8'h00_80
  } scui_source_t;

endpackage

// >>> verilog/scui_priority.sv
// Priority resolver: picks the highest pending enabled event
`timescale 1ns/1ns
`default_nettype none
module scui_priority
  import scui_pkg::*;
(
  input  wire logic [7:0]   pending,
  output scui_source_t      topSource
);

  // Fixed order, buffer empty highest, parity error lowest
  always_comb
  begin
    if (pending[SCUI_BIT_TX_EMPTY])
      topSource = SCUI_SRC_TX_EMPTY;
    else if (pending[SCUI_BIT_OVERCURR])
      topSource = SCUI_SRC_OVERCURR;
    else if (pending[SCUI_BIT_VOLTAGE])
      topSource = SCUI_SRC_VOLTAGE;
    else if (pending[SCUI_BIT_WAIT])
      topSource = SCUI_SRC_WAIT;
    else if (pending[SCUI_BIT_TX_DONE])
      topSource = SCUI_SRC_TX_DONE;
    else if (pending[SCUI_BIT_RX_DONE])
      topSource = SCUI_SRC_RX_DONE;
    else if (pending[SCUI_BIT_PARITY])
      topSource = SCUI_SRC_PARITY;
    else
      topSource = SCUI_SRC_NONE;
  end

endmodule
`default_nettype wire

// >>> verilog/scui_event_unit.sv
// Card interface event unit: flags, enables, selection register, request
//
// Summary of operation
// R1 - Voltage error flag, bit 4, sets when supply leaves chosen range.
// R2 - Wait timeout flag, bit 3, sets when waiting counter expires.
// R3 - Transmitted flag, bit 2, sets when a character send completes.
// R4 - Received flag, bit 1, sets when a character receive completes.
// R5 - Parity flag, bit 0, sets together with transmitted or received flag.
// R6 - Reading the identification register clears all its flags.
// R7 - A flag requests an interrupt only while its enable bit is set.
// R8 - Same-edge order: empty, current, voltage, wait, tx, rx, parity.
// R9 - Software should keep a copy of each identification read.
// R10 - Enables: 7 empty, 5 current, 4 voltage, 3 wait, 2 tx, 1 rx, 0 parity.
// R11 - Enable register shares the address, visible when bank select is 1.
// R12 - Identification and enable registers reset to zero.
// R13 - Software leaves reserved enable bit 6 alone.
// R14 - Selection register: guard 6, repeat 4, prescale 3-2, clock 1, bank 0.
// R15 - Bank select chooses which register set shows at shared addresses.
// R16 - Buffer empty flag, bit 7, sets when buffer moves to shift register.
// R17 - One request: OR of each flag ANDed with its enable bit.
`timescale 1ns/1ns
`default_nettype none
module scui_event_unit
  import scui_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire scui_sfr_req_t sfrReq,
  input  wire scui_events_t  events,
  output logic [7:0]         sfrRdata,
  output logic               sfrRvalid,
  output logic               irqRequest,
  output scui_source_t       topSource,
  output logic               bankSelect,
  output logic               blockGuardEnable,
  output logic               repeatCountSelect,
  output logic [1:0]         altClockPrescale,
  output logic               altClockOutputSelect
);

  logic [7:0]   eventIdent_reg;
  logic [7:0]   eventIdent_next;
  logic [7:0]   eventEnable_reg;
  logic [7:0]   selection_reg;
  logic [7:0]   rawSet;
  logic [7:0]   pendingEnabled;
  logic         hitEvent;
  logic         hitSelection;
  logic         identRead;
  logic         enableWrite;
  logic [7:0]   readMux;
  scui_source_t topSourceNext;

  // Decode of one special function address
  function automatic logic addrHit(input logic [7:0] a, input logic [7:0] b);
    addrHit = (a == b);
  endfunction

  assign hitEvent     = addrHit(sfrReq.addr, SCUI_ADDR_EVENT);
  assign hitSelection = addrHit(sfrReq.addr, SCUI_ADDR_SELECTION);

  // Shared address: bank 0 shows identification, bank 1 the enables
  assign identRead   = sfrReq.rd && hitEvent
                       && !selection_reg[SCUI_SEL_BANK]; // [R15]
  assign enableWrite = sfrReq.wr && hitEvent
                       && selection_reg[SCUI_SEL_BANK]; // [R11]

  // Event strobes mapped to identification bit positions
  always_comb
  begin
    rawSet = SCUI_ZERO;
    rawSet[SCUI_BIT_TX_EMPTY] = events.txEmpty; // [R16]
    rawSet[SCUI_BIT_OVERCURR] = events.overCurrent;
    rawSet[SCUI_BIT_VOLTAGE]  = events.voltageOut; // [R1]
    rawSet[SCUI_BIT_WAIT]     = events.waitExpired; // [R2]
    rawSet[SCUI_BIT_TX_DONE]  = events.txDone; // [R3]
    rawSet[SCUI_BIT_RX_DONE]  = events.rxDone; // [R4]
    // Parity only rides on a tx or rx completion in the same cycle
    rawSet[SCUI_BIT_PARITY]   = events.parityBad
                                && (events.txDone || events.rxDone); // [R5]
  end

  // Read clears all flags, but an event in that cycle still sets:
  // without this, an edge landing on the read would be lost
  always_comb
  begin
    eventIdent_next = eventIdent_reg;
    if (identRead)
      eventIdent_next = SCUI_ZERO; // [R6]
    eventIdent_next = eventIdent_next | rawSet;
  end

  // Identification flags
  always_ff @(posedge clk)
  begin
    if (rst)
      eventIdent_reg <= SCUI_RST_EVENT; // [R12]
    else
      eventIdent_reg <= eventIdent_next;
  end

  // Enable register, reserved bit 6 kept at zero
  always_ff @(posedge clk)
  begin
    if (rst)
      eventEnable_reg <= SCUI_RST_ENABLE; // [R12]
    else if (enableWrite)
      eventEnable_reg <= sfrReq.wdata & SCUI_MASK_ENABLE; // [R10]
  end

  // Selection register, reserved bits 7 and 5 kept at zero
  always_ff @(posedge clk)
  begin
    if (rst)
      selection_reg <= SCUI_RST_SELECTION;
    else if (sfrReq.wr && hitSelection)
      selection_reg <= sfrReq.wdata & SCUI_MASK_SELECTION; // [R14]
  end

  // Selection fields out to the rest of the card interface
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bankSelect           <= SCUI_RST_SELECTION[SCUI_SEL_BANK];
      blockGuardEnable     <= SCUI_RST_SELECTION[SCUI_SEL_GUARD];
      repeatCountSelect    <= SCUI_RST_SELECTION[SCUI_SEL_REPEAT];
      altClockPrescale     <= SCUI_RST_SELECTION[SCUI_SEL_PRESC_HI:
                                                 SCUI_SEL_PRESC_LO];
      altClockOutputSelect <= SCUI_RST_SELECTION[SCUI_SEL_ALTCLK];
    end
    else
    begin
      bankSelect           <= selection_reg[SCUI_SEL_BANK]; // [R15]
      blockGuardEnable     <= selection_reg[SCUI_SEL_GUARD]; // [R14]
      repeatCountSelect    <= selection_reg[SCUI_SEL_REPEAT];
      altClockPrescale     <= selection_reg[SCUI_SEL_PRESC_HI:
                                            SCUI_SEL_PRESC_LO];
      altClockOutputSelect <= selection_reg[SCUI_SEL_ALTCLK];
    end
  end

  // Flags gated by their enables; next state so request tracks flags
  assign pendingEnabled = eventIdent_next & eventEnable_reg; // [R7]

  // Priority order of simultaneous events
  scui_priority u_priority
  (
    .pending   (pendingEnabled),
    .topSource (topSourceNext)
  );

  // Interrupt request and the event to service first
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irqRequest <= 1'b0;
      topSource  <= SCUI_SRC_NONE;
    end
    else
    begin
      irqRequest <= |pendingEnabled; // [R17]
      topSource  <= topSourceNext; // [R8]
    end
  end

  // Read data multiplexer; unmapped addresses read zero
  always_comb
  begin
    readMux = SCUI_ZERO;
    if (hitSelection)
      readMux = selection_reg;
    else if (hitEvent && selection_reg[SCUI_SEL_BANK])
      readMux = eventEnable_reg; // [R11]
    else if (hitEvent)
      readMux = eventIdent_reg;
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sfrRdata  <= SCUI_ZERO;
      sfrRvalid <= 1'b0;
    end
    else
    begin
      sfrRvalid <= sfrReq.rd;
      if (sfrReq.rd)
        sfrRdata <= readMux;
    end
  end

endmodule
`default_nettype wire

// >>> verif/scui_event_unit_assertions.sv
// Checker: port-level assertions of the card event unit
`timescale 1ns/1ns
`default_nettype none
module scui_event_unit_assertions
  import scui_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire scui_sfr_req_t sfrReq,
  input wire scui_events_t  events,
  input wire logic [7:0]    sfrRdata,
  input wire logic          sfrRvalid,
  input wire logic          irqRequest,
  input wire scui_source_t  topSource,
  input wire logic          bankSelect,
  input wire logic          blockGuardEnable,
  input wire logic          repeatCountSelect,
  input wire logic [1:0]    altClockPrescale,
  input wire logic          altClockOutputSelect
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Read answers come one cycle late, data holds in between
  a_rd_answer: assert property (sfrReq.rd |=> sfrRvalid)
    else $error("read not answered");
  a_rd_quiet: assert property (!sfrReq.rd
    |=> !sfrRvalid && $stable(sfrRdata))
    else $error("read data moved without a read");
  // Bank copy lags one edge, so skip reads right after a selection write
  a_read_clears: assert property (sfrReq.rd && !bankSelect
    && !$past(sfrReq.wr && sfrReq.addr == SCUI_ADDR_SELECTION)
    && sfrReq.addr == SCUI_ADDR_EVENT && events == '0 |=> !irqRequest)
    else $error("identification read left a request");
  a_rsv_zero: assert property (sfrReq.rd
    && sfrReq.addr == SCUI_ADDR_EVENT |=> !sfrRdata[6])
    else $error("reserved bit read high");
  // Service order output is one-hot and tracks the request
  a_src_onehot: assert property ($onehot0(topSource))
    else $error("several sources chosen");
  a_src_irq: assert property (
    (topSource != SCUI_SRC_NONE) == irqRequest)
    else $error("source and request disagree");
  a_irq_cause: assert property ($rose(irqRequest)
    |-> $past(|events) || $past(sfrReq.wr))
    else $error("request rose without cause");
  // Selection copies appear two edges after the write
  a_bank_copy: assert property (sfrReq.wr
    && sfrReq.addr == SCUI_ADDR_SELECTION
    |=> ##1 bankSelect == $past(sfrReq.wdata[0], 2))
    else $error("bank select not copied");
  a_sel_copy: assert property (sfrReq.wr
    && sfrReq.addr == SCUI_ADDR_SELECTION |=> ##1
    {blockGuardEnable, repeatCountSelect, altClockPrescale,
     altClockOutputSelect} == {$past(sfrReq.wdata[6], 2),
     $past(sfrReq.wdata[4:1], 2)})
    else $error("selection fields not copied");
endmodule
bind scui_event_unit scui_event_unit_assertions scui_event_unit_assertions_i
(
  .clk(clk), .rst(rst), .sfrReq(sfrReq), .events(events),
  .sfrRdata(sfrRdata), .sfrRvalid(sfrRvalid), .irqRequest(irqRequest),
  .topSource(topSource), .bankSelect(bankSelect),
  .blockGuardEnable(blockGuardEnable), .repeatCountSelect(repeatCountSelect),
  .altClockPrescale(altClockPrescale),
  .altClockOutputSelect(altClockOutputSelect)
);
`default_nettype wire

// >>> verif/scui_core_model.sv
// Partner: core software issuing register accesses
`timescale 1ns/1ns
`default_nettype none
module scui_core_model
  import scui_pkg::*;
(
  input  wire logic         clk,
  input  wire logic [7:0]   sfrRdata,
  input  wire logic         sfrRvalid,
  output var scui_sfr_req_t sfrReq
);
  logic [7:0] identCopy;
  initial sfrReq = '0;
  // One strobe edge; released lines show inverted values, not stale ones
  task automatic access(input logic r, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge clk) sfrReq <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clk) sfrReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Reserved enable bit 6 is always written as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    access(1'b0, a, (a == SCUI_ADDR_EVENT) ? (d & 8'h00_BF) : d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    access(1'b1, a, 8'h00_00);
    @(negedge clk) d = sfrRdata;
    v = sfrRvalid;
    identCopy = d; // Read clears flags, so keep what was seen
  endtask
endmodule
`default_nettype wire

// >>> verif/smartcard_uart_irq_unit_bench.sv
// Testbench: register and event checks of the card event unit
`timescale 1ns/1ns
`default_nettype none
module smartcard_uart_irq_unit_bench
  import scui_pkg::*;
;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  scui_events_t  events = '0;
  scui_sfr_req_t sfrReq;
  scui_source_t  topSource;
  logic [7:0]    sfrRdata;
  logic [7:0]    got;
  logic [7:0]    f;
  logic [7:0]    t;
  logic [1:0]    presc;
  logic          sfrRvalid;
  logic          irqRequest;
  logic          bank;
  logic          guard;
  logic          rep;
  logic          altClk;
  logic          v;
  int            num_errors = 0;
  int            n_checks = 0;
  always #50 clk = ~clk;
  scui_event_unit scui_event_unit_i (.clk(clk), .rst(rst), .sfrReq(sfrReq),
    .events(events), .sfrRdata(sfrRdata), .sfrRvalid(sfrRvalid),
    .irqRequest(irqRequest), .topSource(topSource), .bankSelect(bank),
    .blockGuardEnable(guard), .repeatCountSelect(rep),
    .altClockPrescale(presc), .altClockOutputSelect(altClk));
  scui_core_model scui_core_model_i (.clk(clk), .sfrRdata(sfrRdata),
    .sfrRvalid(sfrRvalid), .sfrReq(sfrReq));
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    scui_core_model_i.rd(a, got, v);
    cmp(got, e);
    cmp({7'h0, v}, 8'h00_01);
  endtask
  // Pulse events, then check request, chosen source and clear on read
  task automatic hit(input logic [6:0] e, input logic [7:0] en);
    @(posedge clk) events <= e;
    @(posedge clk) events <= '0;
    f = {e[6], 1'b0, e[5:1], e[0] & (e[2] | e[1])};
    t = 8'h00_00;
    for (int b = 0; b < 8; b++)
      if (f[b] & en[b]) t = 8'h00_01 << b;
    @(negedge clk);
    cmp({7'h0, irqRequest}, {7'h0, |(f & en)});
    cmp(topSource, t);
    rdc(SCUI_ADDR_EVENT, f);
    cmp(scui_core_model_i.identCopy, f);
    cmp({7'h0, irqRequest}, 8'h00_00);
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence: reset values, selection, enables, event order, masking
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rdc(SCUI_ADDR_SELECTION, 8'h00_08);
    cmp({1'b0, guard, 1'b0, rep, presc, altClk, bank}, 8'h00_08);
    rdc(SCUI_ADDR_EVENT, 8'h00_00);
    rdc(8'h00_10, 8'h00_00);
    scui_core_model_i.wr(SCUI_ADDR_SELECTION, 8'h00_53);
    rdc(SCUI_ADDR_SELECTION, 8'h00_53);
    cmp({1'b0, guard, 1'b0, rep, presc, altClk, bank}, 8'h00_53);
    rdc(SCUI_ADDR_EVENT, 8'h00_00);
    scui_core_model_i.wr(SCUI_ADDR_EVENT, 8'h00_BF);
    rdc(SCUI_ADDR_EVENT, 8'h00_BF);
    scui_core_model_i.wr(SCUI_ADDR_SELECTION, 8'h00_00);
    for (int j = 0; j < 7; j++)
      hit(7'h7F >> j, 8'h00_BF);
    cmp({1'b0, guard, 1'b0, rep, presc, altClk, bank}, 8'h00_00);
    scui_core_model_i.wr(SCUI_ADDR_SELECTION, 8'h00_01);
    scui_core_model_i.wr(SCUI_ADDR_EVENT, 8'h00_0C);
    scui_core_model_i.wr(SCUI_ADDR_SELECTION, 8'h00_00);
    hit(7'h7F, 8'h00_0C);
    // Bank 0 write to the shared address must leave the enables alone
    scui_core_model_i.wr(SCUI_ADDR_EVENT, 8'h00_00);
    scui_core_model_i.wr(SCUI_ADDR_SELECTION, 8'h00_01);
    rdc(SCUI_ADDR_EVENT, 8'h00_0C);
    close_out();
  end
  // Watchdog: the sequence needs well under 2000 cycles
  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
